// [hw/scan_pkg.sv]
package scan_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ        = 10_000_000;
	localparam int FILTER_MS     = 10;
	// Least time: rounded up to whole cycles
	localparam int FILTER_CYCLES = (FILTER_MS * CLK_HZ + 999) / 1000;
	localparam int SCAN_US       = 1000;
	localparam int SCAN_CYCLES   = SCAN_US * (CLK_HZ / 1_000_000);

	// ----------------------------------------
	// Widths and limits
	// ----------------------------------------
	localparam int         NUM_DI     = 11;
	localparam int         NUM_IN     = 17;
	localparam int         NUM_SENSE  = 3;
	localparam int         NUM_OUT    = 2;
	localparam int         NUM_STROBE = 3;
	localparam int         FAIL_W     = 8;
	localparam logic [7:0] FAIL_LIMIT = 8'h05;

	// ----------------------------------------
	// Filtered input bundle positions
	// ----------------------------------------
	localparam int IDX_COIL_A   = 11;
	localparam int IDX_COIL_B   = 12;
	localparam int IDX_SUPPLY_A = 13;
	localparam int IDX_SUPPLY_B = 14;
	localparam int IDX_HOLD_A   = 15;
	localparam int IDX_HOLD_B   = 16;

	// ----------------------------------------
	// High input byte layout
	// ----------------------------------------
	localparam int HI_DI9      = 0;
	localparam int HI_DI_CNT   = 3;
	localparam int HI_HOLD_A   = 3;
	localparam int HI_COIL_A   = 4;
	localparam int HI_COIL_B   = 5;
	localparam int HI_SUPPLY_A = 6;
	localparam int HI_SUPPLY_B = 7;

	// ----------------------------------------
	// Command, strobe and diagnostic bits
	// ----------------------------------------
	localparam int CMD_A_BIT         = 0;
	localparam int CMD_B_BIT         = 1;
	localparam int STROBE_LATCH      = 0;
	localparam int STROBE_LOW        = 1;
	localparam int STROBE_HIGH       = 2;
	localparam int DIAG_VOLT_OFF_BIT = 0;
	localparam int DIAG_OVERRIDE_BIT = 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] OUT_RESET   = 2'h0;
	localparam logic [7:0] IMAGE_RESET = 8'hFF;
	localparam logic [7:0] DIAG_RESET  = 8'h00;

endpackage

// [hw/input_filter.sv]
`timescale 1ns/1ps
`default_nettype none

module input_filter #(
	parameter int COUNT = 100000
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic raw_n,
	output var  logic clean_n
);

	localparam int CNT_W = $clog2(COUNT + 1);

	logic [CNT_W-1:0] cnt_q;

	// ----------------------------------------
	// Stable-level qualifier
	// ----------------------------------------
	// A new level must persist COUNT cycles; any bounce restarts the wait
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q   <= '0;
			clean_n <= 1'b1;
		end
		else if (raw_n == clean_n)
			cnt_q <= '0;
		else if (cnt_q == CNT_W'(COUNT - 1))
		begin
			cnt_q   <= '0;
			clean_n <= raw_n;
		end
		else
			cnt_q <= cnt_q + 1'b1;
	end

endmodule

`default_nettype wire

// [hw/fail_counter.sv]
`timescale 1ns/1ps
`default_nettype none

module fail_counter (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         any_present,
	input  wire logic                         step,
	input  wire logic                         all_absent,
	output var  logic [scan_pkg::FAIL_W-1:0]  count_q,
	output logic                              override
);

	// ----------------------------------------
	// Saturating failure count
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			count_q <= '0;
		else if (any_present)
			count_q <= '0;
		else if (step && all_absent && count_q <= scan_pkg::FAIL_LIMIT)
			count_q <= count_q + 1'b1;
	end

	assign override = count_q > scan_pkg::FAIL_LIMIT;

endmodule

`default_nettype wire

// [hw/dual_output_input_scan.sv]
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Each scan writes output image to latch
// - Two relay drives switch independently
// - Inputs read as two bytes, low first
// - High byte: DI9-11, coils, supplies, seal-in
// - Voltage lines sampled directly, no buffer
// - Separate strobe per buffer and latch
// - All status inputs active low
// - Pulses under 10 ms rejected
// - Supply flag low while supply present
// - Coil flag low when coil attached
// - Sample voltages and bytes before deciding
// - Update images only with voltage present
// - Any voltage off sets fault bit
// - Diagnostic byte returned on request
// - Count scans with all voltages absent
// - Over limit, images update regardless
// - Counter cleared while any voltage present
// - Coil reported true while output on
// - Update command loads output image
// - Link timeout keeps only sealed outputs
module dual_output_input_scan #(
	parameter int FILTER_CYCLES = scan_pkg::FILTER_CYCLES,
	parameter int SCAN_CYCLES   = scan_pkg::SCAN_CYCLES
) (
	// Clock and reset
	input  wire logic                             CORE_CLK,
	input  wire logic                             SYS_RST,
	// Field status inputs, active low
	input  wire logic [scan_pkg::NUM_DI-1:0]      DISCRETE_IN_N,
	input  wire logic                             COIL_A_OK_N,
	input  wire logic                             COIL_B_OK_N,
	input  wire logic                             SUPPLY_A_PRESENT_N,
	input  wire logic                             SUPPLY_B_PRESENT_N,
	input  wire logic                             LATCH_HOLD_A_N,
	input  wire logic                             LATCH_HOLD_B_N,
	input  wire logic [scan_pkg::NUM_SENSE-1:0]   INTERROG_VOLT_N,
	// Controller messages
	input  wire logic                             CMD_VALID,
	input  wire logic [7:0]                       CMD_IMAGE,
	input  wire logic                             DIAG_REQ,
	input  wire logic                             LINK_TIMEOUT,
	// Relay drives and strobes
	output logic                                  OUTPUT_CHAN_A,
	output logic                                  OUTPUT_CHAN_B,
	output logic [scan_pkg::NUM_STROBE-1:0]       STROBE_CONTROL_PORT,
	// Scan results
	output logic [7:0]                            IMAGE_LOW,
	output logic [7:0]                            IMAGE_HIGH,
	output logic                                  HOLD_B_STATUS_N,
	output logic                                  IMAGE_UPDATED,
	output logic                                  FAIL_OVERRIDE,
	// Diagnostic reply
	output logic                                  DIAG_VALID,
	output logic [7:0]                            DIAG_BYTE
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WRITE_OUT,
		ST_READ_LOW,
		ST_READ_HIGH,
		ST_DECIDE
	} scan_state_type;

	localparam int TMR_W = $clog2(SCAN_CYCLES + 1);

	scan_state_type                       state_q;
	logic [TMR_W-1:0]                     tmr_q;
	logic [scan_pkg::NUM_IN-1:0]          raw_n;
	logic [scan_pkg::NUM_IN-1:0]          clean_n;
	logic [scan_pkg::NUM_OUT-1:0]         out_image_q;
	logic [scan_pkg::NUM_OUT-1:0]         out_latch_q;
	logic [7:0]                           low_q;
	logic [7:0]                           high_q;
	logic                                 hold_b_q;
	logic [scan_pkg::NUM_SENSE-1:0]       sense_q;
	logic [7:0]                           low_img_q;
	logic [7:0]                           high_img_q;
	logic                                 hold_b_img_q;
	logic                                 updated_q;
	logic [7:0]                           diag_q;
	logic                                 diag_valid_q;
	logic [7:0]                           diag_byte_q;
	logic [scan_pkg::FAIL_W-1:0]          fail_cnt;
	logic                                 override;
	logic                                 live_present;
	logic                                 sampled_present;
	logic                                 do_update;

	// ----------------------------------------
	// Input qualification
	// ----------------------------------------
	assign raw_n = {LATCH_HOLD_B_N, LATCH_HOLD_A_N, SUPPLY_B_PRESENT_N, SUPPLY_A_PRESENT_N,
		COIL_B_OK_N, COIL_A_OK_N, DISCRETE_IN_N};

	// Polarity kept as received: energised field input stays a zero
	for (genvar i = 0; i < scan_pkg::NUM_IN; i++)
	begin : g_filter
		input_filter #(
			.COUNT (FILTER_CYCLES)
		) u_filter (
			.clk     (CORE_CLK),
			.rst     (SYS_RST),
			.raw_n   (raw_n[i]),
			.clean_n (clean_n[i])
		);
	end

	// ----------------------------------------
	// Scan sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			state_q <= ST_IDLE;
			tmr_q   <= '0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (tmr_q == TMR_W'(SCAN_CYCLES - 1))
					begin
						tmr_q   <= '0;
						state_q <= ST_WRITE_OUT;
					end
					else
						tmr_q <= tmr_q + 1'b1;
				end
				ST_WRITE_OUT: state_q <= ST_READ_LOW;
				ST_READ_LOW:  state_q <= ST_READ_HIGH;
				ST_READ_HIGH: state_q <= ST_DECIDE;
				ST_DECIDE:    state_q <= ST_IDLE;
			endcase
		end
	end

	// One chip enable per access; never two at once
	always_comb
	begin
		STROBE_CONTROL_PORT                        = '0;
		STROBE_CONTROL_PORT[scan_pkg::STROBE_LATCH] = (state_q == ST_WRITE_OUT);
		STROBE_CONTROL_PORT[scan_pkg::STROBE_LOW]   = (state_q == ST_READ_LOW);
		STROBE_CONTROL_PORT[scan_pkg::STROBE_HIGH]  = (state_q == ST_READ_HIGH);
	end

	// ----------------------------------------
	// Output image and latch
	// ----------------------------------------
	// Timeout overrides a command in the same cycle: the safe state comes first
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			out_image_q <= scan_pkg::OUT_RESET;
			out_latch_q <= scan_pkg::OUT_RESET;
		end
		else
		begin
			for (int i = 0; i < scan_pkg::NUM_OUT; i++)
			begin
				if (LINK_TIMEOUT)
				begin
					// Sealed channel keeps its state, the rest drop out
					if (clean_n[scan_pkg::IDX_HOLD_A + i])
					begin
						out_image_q[i] <= 1'b0;
						out_latch_q[i] <= 1'b0;
					end
				end
				else
				begin
					if (CMD_VALID)
						out_image_q[i] <= CMD_IMAGE[scan_pkg::CMD_A_BIT + i];
					if (state_q == ST_WRITE_OUT)
						out_latch_q[i] <= out_image_q[i];
				end
			end
		end
	end

	assign OUTPUT_CHAN_A = out_latch_q[0];
	assign OUTPUT_CHAN_B = out_latch_q[1];

	// ----------------------------------------
	// Input sampling
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			low_q    <= scan_pkg::IMAGE_RESET;
			high_q   <= scan_pkg::IMAGE_RESET;
			hold_b_q <= 1'b1;
			sense_q  <= '1;
		end
		else if (state_q == ST_READ_LOW)
			low_q <= clean_n[7:0];
		else if (state_q == ST_READ_HIGH)
		begin
			high_q[scan_pkg::HI_DI9 +: scan_pkg::HI_DI_CNT] <= clean_n[10:8];
			high_q[scan_pkg::HI_HOLD_A]   <= clean_n[scan_pkg::IDX_HOLD_A];
			high_q[scan_pkg::HI_COIL_A]   <= clean_n[scan_pkg::IDX_COIL_A];
			high_q[scan_pkg::HI_COIL_B]   <= clean_n[scan_pkg::IDX_COIL_B];
			high_q[scan_pkg::HI_SUPPLY_A] <= clean_n[scan_pkg::IDX_SUPPLY_A];
			high_q[scan_pkg::HI_SUPPLY_B] <= clean_n[scan_pkg::IDX_SUPPLY_B];
			// Byte has one seat short, so the second seal-in travels apart
			hold_b_q <= clean_n[scan_pkg::IDX_HOLD_B];
			// Voltage lines are read straight off the pins
			sense_q  <= INTERROG_VOLT_N;
		end
	end

	// ----------------------------------------
	// Voltage failure count
	// ----------------------------------------
	assign live_present    = ~&INTERROG_VOLT_N;
	assign sampled_present = ~&sense_q;

	fail_counter u_fail (
		.clk         (CORE_CLK),
		.rst         (SYS_RST),
		.any_present (live_present),
		.step        (state_q == ST_DECIDE),
		.all_absent  (!sampled_present),
		.count_q     (fail_cnt),
		.override    (override)
	);

	assign do_update = sampled_present || override;

	// ----------------------------------------
	// Working scan buffer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			low_img_q    <= scan_pkg::IMAGE_RESET;
			high_img_q   <= scan_pkg::IMAGE_RESET;
			hold_b_img_q <= 1'b1;
			updated_q    <= 1'b0;
		end
		else
		begin
			updated_q <= 1'b0;
			if (state_q == ST_DECIDE && do_update)
			begin
				low_img_q    <= low_q;
				hold_b_img_q <= hold_b_q;
				updated_q    <= 1'b1;
				high_img_q   <= high_q;
				// Energised output floods the coil sense, so report it healthy
				if (out_latch_q[0])
					high_img_q[scan_pkg::HI_COIL_A] <= 1'b0;
				if (out_latch_q[1])
					high_img_q[scan_pkg::HI_COIL_B] <= 1'b0;
			end
		end
	end

	assign IMAGE_LOW       = low_img_q;
	assign IMAGE_HIGH      = high_img_q;
	assign HOLD_B_STATUS_N = hold_b_img_q;
	assign IMAGE_UPDATED   = updated_q;
	assign FAIL_OVERRIDE   = override;

	// ----------------------------------------
	// Diagnostic byte
	// ----------------------------------------
	// Fault bits clear on a request; a fault in the same cycle still lands
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			diag_q       <= scan_pkg::DIAG_RESET;
			diag_valid_q <= 1'b0;
			diag_byte_q  <= scan_pkg::DIAG_RESET;
		end
		else
		begin
			diag_valid_q <= DIAG_REQ;
			if (DIAG_REQ)
			begin
				diag_byte_q <= diag_q;
				diag_q      <= scan_pkg::DIAG_RESET;
			end
			if (state_q == ST_DECIDE && |sense_q)
				diag_q[scan_pkg::DIAG_VOLT_OFF_BIT] <= 1'b1;
			if (override)
				diag_q[scan_pkg::DIAG_OVERRIDE_BIT] <= 1'b1;
		end
	end

	assign DIAG_VALID = diag_valid_q;
	assign DIAG_BYTE  = diag_byte_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	chk_latch_write: assert property (
		state_q == ST_WRITE_OUT && !LINK_TIMEOUT |=> out_latch_q == $past(out_image_q))
		else $error("output latch not written from image");
	chk_cmd_load: assert property (
		CMD_VALID && !LINK_TIMEOUT ##1 state_q == ST_WRITE_OUT && !LINK_TIMEOUT
		|=> out_latch_q == $past(CMD_IMAGE[1:0], 2))
		else $error("command image not reaching relays");
	chk_strobe_single: assert property (
		$onehot0(STROBE_CONTROL_PORT))
		else $error("two strobes active together");
	chk_read_order: assert property (
		state_q == ST_WRITE_OUT |=> state_q == ST_READ_LOW ##1 state_q == ST_READ_HIGH ##1 state_q == ST_DECIDE)
		else $error("scan access order broken");
	chk_update_gate: assert property (
		state_q == ST_DECIDE && !sampled_present && !override |=> !IMAGE_UPDATED && $stable(IMAGE_LOW))
		else $error("image updated without voltage");
	chk_fault_set: assert property (
		state_q == ST_DECIDE && |sense_q |=> diag_q[scan_pkg::DIAG_VOLT_OFF_BIT])
		else $error("voltage fault bit not set");
	chk_diag_reply: assert property (
		DIAG_REQ |=> DIAG_VALID && DIAG_BYTE == $past(diag_q))
		else $error("diagnostic reply wrong");
	chk_fail_clear: assert property (
		live_present |=> fail_cnt == '0)
		else $error("failure count not cleared");
	chk_fail_sat: assert property (
		fail_cnt <= scan_pkg::FAIL_LIMIT + 8'h01)
		else $error("failure count past saturation");
	chk_coil_mask: assert property (
		state_q == ST_DECIDE && do_update && out_latch_q[0] |=> !IMAGE_HIGH[scan_pkg::HI_COIL_A])
		else $error("coil fault shown while output on");
	chk_timeout_safe: assert property (
		LINK_TIMEOUT && clean_n[scan_pkg::IDX_HOLD_A] |=> !OUTPUT_CHAN_A)
		else $error("unsealed output kept after timeout");

endmodule

`default_nettype wire

// [testbench/controller_model.sv]
`timescale 1ns/1ps
`default_nettype none

module controller_model (
	// Clock
	input  wire logic       clk,
	// Diagnostic reply
	input  wire logic       diag_valid,
	input  wire logic [7:0] diag_byte,
	// Messages
	output var  logic       cmd_valid,
	output var  logic [7:0] cmd_image,
	output var  logic       diag_req,
	output var  logic       link_timeout
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_image = 8'h00;
		diag_req = 1'b0;
		link_timeout = 1'b0;
	end

	// Upper bits are driven high so that a design reading them would show it
	task automatic send_cmd(input logic [1:0] img);
	begin
		@(negedge clk);
		cmd_image = {6'h3F, img};
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		// Released byte no longer shows the command
		cmd_image = ~cmd_image;
	end
	endtask

	task automatic request_diag(output logic [7:0] got);
		int i;
	begin
		got = 8'hXX;
		@(negedge clk);
		diag_req = 1'b1;
		@(negedge clk);
		diag_req = 1'b0;
		for (i = 0; i < 4 && diag_valid !== 1'b1; i++)
			@(negedge clk);
		if (diag_valid === 1'b1)
			got = diag_byte;
	end
	endtask

	task automatic pulse_timeout;
	begin
		@(negedge clk);
		link_timeout = 1'b1;
		@(negedge clk);
		link_timeout = 1'b0;
	end
	endtask
endmodule

`default_nettype wire

// [testbench/test_dual_output_input_scan.sv]
`timescale 1ns/1ps
`default_nettype none

module test_dual_output_input_scan;
	localparam int FILT = 4;
	localparam int SCAN = 8;

	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [10:0] di_n = 11'h7FF;
	logic        coil_a_n = 1'b1;
	logic        coil_b_n = 1'b1;
	logic        sup_a_n = 1'b1;
	logic        sup_b_n = 1'b1;
	logic        hold_a_n = 1'b1;
	logic        hold_b_n = 1'b1;
	logic [2:0]  volt_n = 3'h0;
	logic        cmd_valid, diag_req, link_timeout, diag_valid;
	logic [7:0]  cmd_image, diag_byte, img_lo, img_hi;
	logic        out_a, out_b, hold_b_st, updated, override;
	logic [2:0]  strobe;
	logic [7:0]  d;
	int          errors = 0;
	int          n_compared = 0;
	int          k;

	always #50 core_clk = ~core_clk;

	dual_output_input_scan #(.FILTER_CYCLES(FILT), .SCAN_CYCLES(SCAN)) u_dual_output_input_scan (
		.CORE_CLK(core_clk), .SYS_RST(sys_rst), .DISCRETE_IN_N(di_n),
		.COIL_A_OK_N(coil_a_n), .COIL_B_OK_N(coil_b_n),
		.SUPPLY_A_PRESENT_N(sup_a_n), .SUPPLY_B_PRESENT_N(sup_b_n),
		.LATCH_HOLD_A_N(hold_a_n), .LATCH_HOLD_B_N(hold_b_n), .INTERROG_VOLT_N(volt_n),
		.CMD_VALID(cmd_valid), .CMD_IMAGE(cmd_image), .DIAG_REQ(diag_req), .LINK_TIMEOUT(link_timeout),
		.OUTPUT_CHAN_A(out_a), .OUTPUT_CHAN_B(out_b), .STROBE_CONTROL_PORT(strobe),
		.IMAGE_LOW(img_lo), .IMAGE_HIGH(img_hi), .HOLD_B_STATUS_N(hold_b_st),
		.IMAGE_UPDATED(updated), .FAIL_OVERRIDE(override), .DIAG_VALID(diag_valid), .DIAG_BYTE(diag_byte)
	);

	controller_model u_controller_model (
		.clk(core_clk), .diag_valid(diag_valid), .diag_byte(diag_byte), .cmd_valid(cmd_valid),
		.cmd_image(cmd_image), .diag_req(diag_req), .link_timeout(link_timeout)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
	begin
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	end
	endtask

	task automatic wait_update;
		int i;
	begin
		@(negedge core_clk);
		for (i = 0; i < 120 && updated !== 1'b1; i++)
			@(negedge core_clk);
		if (updated !== 1'b1)
			check(8'h00, 8'h01, "no image update");
	end
	endtask

	// Two updates: the filter settles and a full scan samples the new level
	task automatic settle;
	begin
		repeat (FILT + 2) @(negedge core_clk);
		wait_update();
		wait_update();
	end
	endtask

	task automatic count_updates(input int cycles, output int n);
	begin
		n = 0;
		repeat (cycles)
		begin
			@(negedge core_clk);
			if (updated === 1'b1)
				n++;
		end
	end
	endtask

	task automatic summarize;
	begin
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask

	initial
	begin
		#(20000 * 100);
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (16) @(negedge core_clk);
		check({out_b, out_a}, 8'h00, "reset outputs");
		check(img_lo, 8'hFF, "reset image");
		sys_rst = 1'b0;
		for (k = 0; k < 120 && strobe === 3'h0; k++)
			@(negedge core_clk);
		check(strobe, 8'h01, "latch strobe");
		@(negedge core_clk);
		check(strobe, 8'h02, "low strobe");
		@(negedge core_clk);
		check(strobe, 8'h04, "high strobe");
		$display("test strobes done");

		for (k = 0; k < 4; k++)
		begin
			u_controller_model.send_cmd(k[1:0]);
			wait_update();
			wait_update();
			check({out_b, out_a}, 8'(k), "relay image");
		end
		$display("test commands done");

		di_n = 11'h5A3;
		coil_a_n = 1'b0;
		sup_b_n = 1'b0;
		hold_a_n = 1'b0;
		settle();
		check(img_lo, 8'hA3, "low byte");
		// Both relays are still on from the last command, so both coil seats read healthy
		check(img_hi, 8'h45, "high byte");
		check(hold_b_st, 8'h01, "seal b");
		u_controller_model.send_cmd(2'h2);
		coil_b_n = 1'b1;
		settle();
		check(img_hi[5], 8'h00, "coil b masked on");
		check(img_hi[4], 8'h00, "coil a measured");
		u_controller_model.send_cmd(2'h0);
		settle();
		check(img_hi[5], 8'h01, "coil b measured off");
		$display("test mapping done");

		// Input 1 rests inactive; a pulse one cycle short of the filter span must vanish
		@(negedge core_clk);
		di_n[0] = 1'b0;
		repeat (FILT - 1) @(negedge core_clk);
		di_n[0] = 1'b1;
		wait_update();
		wait_update();
		check(img_lo, 8'hA3, "short pulse");
		$display("test filter done");

		u_controller_model.request_diag(d);
		volt_n = 3'h7;
		di_n = 11'h0FF;
		repeat (SCAN + 4) @(negedge core_clk);
		count_updates(3 * (SCAN + 4), k);
		check(8'(k), 8'h00, "gated updates");
		check(img_lo, 8'hA3, "held image");
		check(override, 8'h00, "early override");
		wait_update();
		check(override, 8'h01, "override");
		check(img_lo, 8'hFF, "override image");
		wait_update();
		check(override, 8'h01, "saturated override");
		u_controller_model.request_diag(d);
		check(d[0], 8'h01, "volt off bit");
		check(d[1], 8'h01, "override seen bit");
		volt_n = 3'h3;
		@(negedge core_clk);
		check(override, 8'h00, "counter cleared");
		u_controller_model.request_diag(d);
		di_n = 11'h7F0;
		settle();
		check(img_lo, 8'hF0, "one volt present");
		u_controller_model.request_diag(d);
		check(d[0], 8'h01, "partial volt off");
		volt_n = 3'h0;
		$display("test voltages done");

		u_controller_model.send_cmd(2'h3);
		hold_a_n = 1'b0;
		hold_b_n = 1'b1;
		settle();
		u_controller_model.pulse_timeout();
		@(negedge core_clk);
		check({out_b, out_a}, 8'h01, "timeout seal");
		$display("test timeout done");
		summarize();
	end
endmodule

`default_nettype wire
